// [csi_params.svh]
/*
  Constants of the charger status and serial target block: offsets,
  field positions, reset values and timing counts.
  Assumes a 40 MHz system clock.
*/
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH

`define CSI_TARGET_ADDR   7'h6b
`define CSI_REG_FIRST     8'h00
`define CSI_REG_LAST      8'h0b
`define CSI_REG_FAULT     8'h09
`define CSI_READ_FILL     8'hff
`define CSI_FIRST_REGISTER_INDEX_RST     8'h17
`define CSI_REG01_RST     8'h1a
`define CSI_SPC_HI        6
`define CSI_SPC_LO        5
`define CSI_STAT_ON       2'h0
`define CSI_STAT_OFF      2'h3
`define CSI_TFLT_BIT      0
`define CSI_NONTHERM_MASK 8'hfe
`define CSI_STD_KBPS      100
`define CSI_FAST_KBPS     400
`define CSI_CLK_MHZ       40
`define CSI_CLK_HZ        40000000
`define CSI_INT_PULSE_US  256
`define CSI_INT_CYC       (`CSI_INT_PULSE_US * `CSI_CLK_MHZ)
`define CSI_BLINK_HZ      1
`define CSI_BLINK_HALF    (`CSI_CLK_HZ / (2 * `CSI_BLINK_HZ))

`endif

// [csi_pkg.sv]
/*
  Types of the charger status and serial target block.
  Uses literal widths and encodings; csi_params.svh is not included.
*/
package csi_pkg;

  typedef enum logic [3:0] {
    CSI_IDLE  = 4'h0,
    CSI_ADDR  = 4'h1,
    CSI_AACK  = 4'h2,
    CSI_IDX   = 4'h3,
    CSI_IACK  = 4'h4,
    CSI_WR    = 4'h5,
    CSI_WACK  = 4'h6,
    CSI_RD    = 4'h7,
    CSI_RACK  = 4'h8,
    CSI_RNXT  = 4'h9,
    CSI_FETCH = 4'ha
  } csi_st_t;

  typedef struct packed {
    logic             lrst_s1;
    logic             lrst_s2;
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_s3;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_s3;
    logic             ack_s1;
    logic             ack_s2;
    csi_st_t          st;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic             rw;
    logic             first;
    logic             sda_oe_n;
    logic             scl_oe_n;
    logic             req_t;
    logic             stat_off;
    logic [11:0][7:0] mem;
  } csi_link_t;

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        off_s1;
    logic        off_s2;
    logic        ts_s1;
    logic        ts_s2;
    logic        ack_t;
    logic [7:0]  latch;
    logic [7:0]  hold;
    logic        armed;
    logic        read_seen;
    logic        ig;
    logic        ig_n;
    logic        src_q;
    logic        done_q;
    logic        dpm_q;
    logic        tflt_q;
    logic [13:0] int_cnt;
    logic        int_n;
    logic [24:0] blink_cnt;
    logic        blink;
    logic        stat_oe_n;
  } csi_sys_t;

endpackage

// [csi_charger_ctl.sv]
/*
  Charger host-facing logic: serial register target on its own link
  clock, latched fault register, input-good, charge-state pin and host
  interrupt pulse on the system clock.
  Assumes open-drain pins resolved outside and a free-running link_clk.
*/
// Operation
// - input good only when all qualifications met
// - state control 11 floats charge-state pin
// - pin low charging, released otherwise
// - pin blinks at 1 Hz when suspended
// - listed events emit 256 us interrupt pulse
// - limit event interrupt can be masked
// - fault pulses interrupt and stays latched
// - no new fault interrupt until read, clear
// - first read latched, second read present
// - thermistor field always shows live sense
// - answer only target address 6BH, indices 0-0B
// - read above 0B returns FF
// - undefined index gets NACK, back to idle
// - standard and fast mode speeds supported
// - START and STOP detected from SDA with SCL high
// - change SDA only while SCL low
// - eight bits, MSB first, then acknowledge
// - target may stretch SCL between bytes
// - receiver pulls SDA low on ninth clock
// - address then direction bit, 1 reads
// - burst access, but not fault register
// - state control 00 enables pin
`include "csi_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csi_charger_ctl #(
  parameter int unsigned INT_CYC    = `CSI_INT_CYC,
  parameter int unsigned BLINK_HALF = `CSI_BLINK_HALF
) (
  // System clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  // Serial link pins.
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Charger conditions.
  input  wire logic [3:0] input_qual_ok,
  input  wire logic       src_detect_done,
  input  wire logic       charging,
  input  wire logic       charge_done,
  input  wire logic       charge_suspend,
  input  wire logic       boost_suspend,
  input  wire logic       input_voltage_limit_event,
  input  wire logic       input_current_limit_event,
  input  wire logic       dpm_int_mask,
  input  wire logic [7:0] fault_event,
  input  wire logic       thermistor_sense_pin,
  // Status outputs.
  output logic            input_good_flag,
  output logic            input_good_pin_n,
  output logic            stat_o,
  output logic            stat_oe_n,
  output logic            host_int_n
);
  import csi_pkg::*;

  csi_link_t l_q;
  csi_link_t l_d;
  csi_sys_t  s_q;
  csi_sys_t  s_d;

  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       do_load;
  logic [7:0] ld_val;

  // Edges of the twice-synchronised link pins; the link clock oversamples
  // even fast mode many times per bit.
  always_comb begin
    rise    = l_q.scl_s2 & ~l_q.scl_s3;
    fall    = ~l_q.scl_s2 & l_q.scl_s3;
    start_c = l_q.scl_s2 & l_q.scl_s3 & l_q.sda_s3 & ~l_q.sda_s2;
    stop_c  = l_q.scl_s2 & l_q.scl_s3 & ~l_q.sda_s3 & l_q.sda_s2;
  end

  // Link side protocol engine and register store.
  always_comb begin
    l_d      = l_q;
    do_load  = 1'b0;
    ld_val   = `CSI_READ_FILL;
    l_d.lrst_s1 = nrst;
    l_d.lrst_s2 = l_q.lrst_s1;
    l_d.scl_s1  = scl_i;
    l_d.scl_s2  = l_q.scl_s1;
    l_d.scl_s3  = l_q.scl_s2;
    l_d.sda_s1  = sda_i;
    l_d.sda_s2  = l_q.sda_s1;
    l_d.sda_s3  = l_q.sda_s2;
    l_d.ack_s1  = s_q.ack_t;
    l_d.ack_s2  = l_q.ack_s1;
    l_d.stat_off = l_q.mem[0][`CSI_SPC_HI:`CSI_SPC_LO]
                   == `CSI_STAT_OFF;
    if (!l_q.lrst_s2) begin
      l_d.st       = CSI_IDLE;
      l_d.cnt      = 4'h0;
      l_d.sh       = 8'h00;
      l_d.ptr      = `CSI_REG_FIRST;
      l_d.rw       = 1'b0;
      l_d.first    = 1'b0;
      l_d.sda_oe_n = 1'b1;
      l_d.scl_oe_n = 1'b1;
      l_d.req_t    = 1'b0;
      l_d.mem      = '0;
      l_d.mem[0]   = `CSI_FIRST_REGISTER_INDEX_RST;
      l_d.mem[1]   = `CSI_REG01_RST;
    end else if (start_c) begin
      l_d.st       = CSI_ADDR;
      l_d.cnt      = 4'h0;
      l_d.sda_oe_n = 1'b1;
      l_d.scl_oe_n = 1'b1;
    end else if (stop_c) begin
      l_d.st       = CSI_IDLE;
      l_d.sda_oe_n = 1'b1;
      l_d.scl_oe_n = 1'b1;
    end else begin
      case (l_q.st)
        CSI_ADDR, CSI_IDX, CSI_WR: begin
          if (rise) begin
            l_d.sh  = {l_q.sh[6:0], l_q.sda_s2};
            l_d.cnt = 4'(l_q.cnt + 4'h1);
          end else if (fall && l_q.cnt == 4'h8) begin
            l_d.st = CSI_IDLE;
            if (l_q.st == CSI_ADDR) begin
              if (l_q.sh[7:1] == `CSI_TARGET_ADDR) begin
                l_d.rw       = l_q.sh[0];
                l_d.sda_oe_n = 1'b0;
                l_d.st       = CSI_AACK;
              end
            end else if (l_q.st == CSI_IDX) begin
              if (l_q.sh <= `CSI_REG_LAST) begin
                l_d.ptr      = l_q.sh;
                l_d.sda_oe_n = 1'b0;
                l_d.st       = CSI_IACK;
              end
            end else begin
              if (l_q.ptr <= `CSI_REG_LAST &&
                  l_q.ptr != `CSI_REG_FAULT) begin
                l_d.mem[l_q.ptr[3:0]] = l_q.sh;
              end
              l_d.sda_oe_n = 1'b0;
              l_d.st       = CSI_WACK;
            end
          end
        end
        CSI_AACK: begin
          if (fall) begin
            if (l_q.rw) begin
              l_d.first = 1'b1;
              if (l_q.ptr == `CSI_REG_FAULT) begin
                l_d.scl_oe_n = 1'b0;
                l_d.sda_oe_n = 1'b1;
                l_d.req_t    = ~l_q.req_t;
                l_d.st       = CSI_FETCH;
              end else begin
                do_load = 1'b1;
              end
            end else begin
              l_d.sda_oe_n = 1'b1;
              l_d.cnt      = 4'h0;
              l_d.st       = CSI_IDX;
            end
          end
        end
        CSI_IACK, CSI_WACK: begin
          if (fall) begin
            if (l_q.st == CSI_WACK) begin
              l_d.ptr = 8'(l_q.ptr + 8'h01);
            end
            l_d.sda_oe_n = 1'b1;
            l_d.cnt      = 4'h0;
            l_d.st       = CSI_WR;
          end
        end
        CSI_FETCH: begin
          if (l_q.ack_s2 == l_q.req_t) begin
            ld_val       = s_q.hold;
            do_load      = 1'b1;
            l_d.scl_oe_n = 1'b1;
          end
        end
        CSI_RD: begin
          if (rise) begin
            l_d.cnt = 4'(l_q.cnt + 4'h1);
          end else if (fall) begin
            if (l_q.cnt == 4'h8) begin
              l_d.sda_oe_n = 1'b1;
              l_d.st       = CSI_RACK;
            end else begin
              l_d.sh       = {l_q.sh[6:0], 1'b1};
              l_d.sda_oe_n = l_q.sh[6];
            end
          end
        end
        CSI_RACK: begin
          if (rise) begin
            l_d.st = l_q.sda_s2 ? CSI_IDLE : CSI_RNXT;
          end
        end
        CSI_RNXT: begin
          if (fall) begin
            l_d.ptr   = 8'(l_q.ptr + 8'h01);
            l_d.first = 1'b0;
            do_load   = 1'b1;
          end
        end
        default: begin
          l_d.st       = CSI_IDLE;
          l_d.sda_oe_n = 1'b1;
        end
      endcase
    end
    if (do_load && l_q.st != CSI_FETCH) begin
      if (l_d.ptr <= `CSI_REG_LAST && l_d.ptr != `CSI_REG_FAULT) begin
        ld_val = l_q.mem[l_d.ptr[3:0]];
      end else begin
        ld_val = `CSI_READ_FILL;
      end
    end
    if (do_load) begin
      l_d.sh       = ld_val;
      l_d.sda_oe_n = ld_val[7];
      l_d.cnt      = 4'h0;
      l_d.st       = CSI_RD;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  logic       rd_evt;
  logic       good_now;
  logic       dpm_now;
  logic       new_flt;
  logic       fire_flt;
  logic       evt_other;
  logic       blink_wrap;
  logic [7:0] live;
  logic [7:0] hold_v;

  // System side status, fault latch and interrupt pulse.
  always_comb begin
    s_d        = s_q;
    s_d.req_s1 = l_q.req_t;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    s_d.off_s1 = l_q.stat_off;
    s_d.off_s2 = s_q.off_s1;
    s_d.ts_s1  = thermistor_sense_pin;
    s_d.ts_s2  = s_q.ts_s1;
    rd_evt     = s_q.req_s2 ^ s_q.req_s3;
    good_now   = &input_qual_ok & src_detect_done;
    dpm_now    = input_voltage_limit_event | input_current_limit_event;
    live       = fault_event & `CSI_NONTHERM_MASK;
    hold_v     = s_q.latch;
    hold_v[`CSI_TFLT_BIT] = s_q.ts_s2;
    new_flt    = (|(live & ~s_q.latch)) | (s_q.ts_s2 & ~s_q.tflt_q);
    fire_flt   = new_flt & s_q.armed;
    evt_other  = (src_detect_done & ~s_q.src_q) | (good_now ^ s_q.ig) |
                 (charge_done & ~s_q.done_q) | fire_flt;
    blink_wrap = s_q.blink_cnt == 25'(BLINK_HALF - 1);
    if (!nrst) begin
      s_d.ack_t     = 1'b0;
      s_d.latch     = 8'h00;
      s_d.hold      = 8'h00;
      s_d.armed     = 1'b1;
      s_d.read_seen = 1'b0;
      s_d.ig        = 1'b0;
      s_d.ig_n      = 1'b1;
      s_d.src_q     = 1'b0;
      s_d.done_q    = 1'b0;
      s_d.dpm_q     = 1'b0;
      s_d.tflt_q    = 1'b0;
      s_d.int_cnt   = 14'h0000;
      s_d.int_n     = 1'b1;
      s_d.blink_cnt = 25'h0000000;
      s_d.blink     = 1'b0;
      s_d.stat_oe_n = 1'b1;
    end else begin
      s_d.ig     = good_now;
      s_d.ig_n   = ~good_now;
      s_d.src_q  = src_detect_done;
      s_d.done_q = charge_done;
      s_d.dpm_q  = dpm_now;
      s_d.tflt_q = s_q.ts_s2;
      if (fire_flt) begin
        s_d.armed = 1'b0;
      end else if (s_q.read_seen && s_q.latch == 8'h00) begin
        s_d.armed     = 1'b1;
        s_d.read_seen = 1'b0;
      end
      if (rd_evt) begin
        s_d.hold      = hold_v;
        s_d.latch     = live;
        s_d.ack_t     = s_q.req_s2;
        s_d.read_seen = 1'b1;
      end else begin
        s_d.latch = s_q.latch | live;
      end
      if (evt_other | (dpm_now & ~s_q.dpm_q & ~dpm_int_mask)) begin
        s_d.int_cnt = 14'(INT_CYC - 1);
        s_d.int_n   = 1'b0;
      end else if (s_q.int_cnt != 14'h0000) begin
        s_d.int_cnt = 14'(s_q.int_cnt - 14'h0001);
      end else begin
        s_d.int_n = 1'b1;
      end
      if (blink_wrap) begin
        s_d.blink_cnt = 25'h0000000;
        s_d.blink     = ~s_q.blink;
      end else begin
        s_d.blink_cnt = 25'(s_q.blink_cnt + 25'h0000001);
      end
      if (s_q.off_s2) begin
        s_d.stat_oe_n = 1'b1;
      end else if (charge_suspend | boost_suspend) begin
        s_d.stat_oe_n = s_q.blink;
      end else begin
        s_d.stat_oe_n = ~charging;
      end
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  assign scl_o            = 1'b0;
  assign sda_o            = 1'b0;
  assign stat_o           = 1'b0;
  assign scl_oe_n         = l_q.scl_oe_n;
  assign sda_oe_n         = l_q.sda_oe_n;
  assign input_good_flag  = s_q.ig;
  assign input_good_pin_n = s_q.ig_n;
  assign stat_oe_n        = s_q.stat_oe_n;
  assign host_int_n       = s_q.int_n;

  sequence byte_end_s;
    fall && l_q.cnt == 4'h8;
  endsequence

  sequence wr_ack_end_s;
    l_q.st == CSI_WACK && fall;
  endsequence

  chk_good_flag: assert property (@(posedge clock) disable iff (!nrst)
    good_now |=> input_good_flag && !input_good_pin_n)
    else $error("input good flag not set");
  chk_stat_float: assert property (@(posedge clock) disable iff (!nrst)
    s_q.off_s2 |=> stat_oe_n)
    else $error("charge-state pin not floated");
  chk_stat_low: assert property (@(posedge clock) disable iff (!nrst)
    (!s_q.off_s2 && charging && !charge_suspend && !boost_suspend)
    |=> !stat_oe_n)
    else $error("charge-state pin not low while charging");
  chk_blink_rate: assert property (@(posedge clock) disable iff (!nrst)
    !blink_wrap |=> $stable(s_q.blink))
    else $error("blink toggled early");
  chk_int_width: assert property (@(posedge clock) disable iff (!nrst)
    $rose(host_int_n) |-> $past(s_q.int_cnt) == 14'h0000)
    else $error("interrupt pulse ended early");
  chk_dpm_mask: assert property (@(posedge clock) disable iff (!nrst)
    (dpm_int_mask && !evt_other && host_int_n) |=> host_int_n)
    else $error("masked limit event raised interrupt");
  chk_fault_hold: assert property (@(posedge clock) disable iff (!nrst)
    rd_evt |=> s_q.hold == $past(hold_v))
    else $error("fault read did not return latched value");
  chk_fault_quiet: assert property (@(posedge clock) disable iff (!nrst)
    (!s_q.armed && new_flt && !rd_evt) |=> !s_q.armed)
    else $error("fault interrupt rearmed without read");
  chk_therm_live: assert property (@(posedge clock) disable iff (!nrst)
    rd_evt |=> s_q.hold[`CSI_TFLT_BIT] == $past(s_q.ts_s2))
    else $error("thermistor field not live");
  chk_idx_nack: assert property (@(posedge link_clk)
    disable iff (!l_q.lrst_s2)
    (l_q.st == CSI_IDX && !start_c && !stop_c && l_q.sh > `CSI_REG_LAST)
    ##0 byte_end_s |=> l_q.st == CSI_IDLE && sda_oe_n)
    else $error("undefined index acknowledged");
  chk_addr_nack: assert property (@(posedge link_clk)
    disable iff (!l_q.lrst_s2)
    (l_q.st == CSI_ADDR && !start_c && !stop_c &&
     l_q.sh[7:1] != `CSI_TARGET_ADDR) ##0 byte_end_s |=> sda_oe_n)
    else $error("foreign address acknowledged");
  chk_ptr_step: assert property (@(posedge link_clk)
    disable iff (!l_q.lrst_s2)
    (wr_ack_end_s and !start_c && !stop_c)
    |=> l_q.ptr == 8'($past(l_q.ptr) + 8'h01))
    else $error("pointer did not advance");

endmodule

`default_nettype wire

// [csi_host_model.sv]
/*
  Serial bus host model that drives SCL and SDA toward the target.
  Assumes pull-ups on both wires, with the bench resolving the levels.
*/
`timescale 1ns/1ps
`default_nettype none

module csi_host_model (
  // Resolved wire levels.
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Host drive, high means released.
  output logic      host_scl,
  output logic      host_sda,
  output logic      hang
);
  localparam int T = 850;

  initial begin
    host_scl = 1'b1;
    host_sda = 1'b1;
    hang     = 1'b0;
  end

  // Releases SCL and waits while the target stretches it.
  task automatic scl_up();
    int i;
    host_scl = 1'b1;
    i = 0;
    while (scl_line !== 1'b1 && i < 4000) begin
      #10;
      i++;
    end
    if (i >= 4000) hang = 1'b1;
  endtask

  task automatic start();
    host_sda = 1'b1;
    #T;
    scl_up();
    #T;
    host_sda = 1'b0;
    #T;
    host_scl = 1'b0;
    #T;
  endtask

  task automatic stop();
    host_sda = 1'b0;
    #T;
    scl_up();
    #T;
    host_sda = 1'b1;
    #T;
  endtask

  // Drives one bit while SCL is low, samples it while high.
  task automatic bit_x(input logic b, output logic r);
    host_sda = b;
    #T;
    scl_up();
    #T;
    r = sda_line;
    host_scl = 1'b0;
    #T;
  endtask

  // Eight bits MSB first, then the acknowledge slot.
  task automatic byte_x(input logic [7:0] d, input logic ab,
                        output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ab, ack);
  endtask
endmodule

`default_nettype wire

// [csi_charger_ctl_tb.sv]
/*
  Self-checking bench of the charger status and serial target block.
  Assumes the host model and the design package are compiled first.
*/
`include "csi_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csi_charger_ctl_tb;
  import csi_pkg::*;
  localparam int IC = 16;
  localparam int BH = 8;
  logic       clock, nrst, link_clk, scl_w, sda_w, hang, ak;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, host_scl, host_sda;
  logic [3:0] input_qual_ok;
  logic       src_detect_done, charging, charge_done, charge_suspend;
  logic       boost_suspend, input_voltage_limit_event;
  logic       input_current_limit_event, dpm_int_mask;
  logic [7:0] fault_event, rd;
  logic       thermistor_sense_pin, input_good_flag, input_good_pin_n;
  logic       stat_o, stat_oe_n, host_int_n;
  int         n_errors, total_checks, seed, flt;
  int         mem [12];

  assign scl_w = host_scl & (scl_oe_n | scl_o);
  assign sda_w = host_sda & (sda_oe_n | sda_o);

  csi_charger_ctl #(.INT_CYC(IC), .BLINK_HALF(BH)) uut (
    .clock, .nrst, .link_clk, .scl_i(scl_w), .scl_o, .scl_oe_n,
    .sda_i(sda_w), .sda_o, .sda_oe_n, .input_qual_ok, .src_detect_done,
    .charging, .charge_done, .charge_suspend, .boost_suspend,
    .input_voltage_limit_event, .input_current_limit_event, .dpm_int_mask,
    .fault_event, .thermistor_sense_pin, .input_good_flag,
    .input_good_pin_n, .stat_o, .stat_oe_n, .host_int_n
  );
  csi_host_model host (.scl_line(scl_w), .sda_line(sda_w), .host_scl,
    .host_sda, .hang);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Counts low cycles of the interrupt after a stimulus.
  task automatic int_chk(input int exp);
    int lo;
    lo = 0;
    for (int i = 0; i < IC + 8; i++) begin
      @(negedge clock);
      if (host_int_n === 1'b0) lo++;
    end
    chk("int cycles", lo, exp);
  endtask

  task automatic st_chk(input logic e);
    repeat (4) @(negedge clock);
    chk("stat", stat_oe_n, e);
  endtask

  // Waits for one toggle, then times the next half period.
  task automatic blink_chk();
    int n;
    logic s;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      s = stat_oe_n;
      n = 0;
      while (stat_oe_n === s && n < 4 * BH) begin
        @(negedge clock);
        n++;
      end
    end
    chk("blink half", n, BH);
  endtask

  task automatic addr(input logic [6:0] a, input logic r);
    host.start();
    host.byte_x({a, r}, 1'b1, rd, ak);
  endtask

  task automatic wr_regs(input int idx, input int n);
    addr(`CSI_TARGET_ADDR, 1'b0);
    chk("wr addr ack", ak, 0);
    for (int i = -1; i < n; i++) begin
      host.byte_x(i < 0 ? idx[7:0] : mem[idx + i][7:0], 1'b1, rd, ak);
      chk("wr ack", ak, 0);
    end
    host.stop();
  endtask

  task automatic rd_regs(input int idx, input int n);
    int p;
    int e;
    addr(`CSI_TARGET_ADDR, 1'b0);
    host.byte_x(idx[7:0], 1'b1, rd, ak);
    addr(`CSI_TARGET_ADDR, 1'b1);
    chk("rd addr ack", ak, 0);
    for (int i = 0; i < n; i++) begin
      p = idx + i;
      e = (p > 11 || p == 9) ? 'hff : mem[p];
      if (n == 1 && p == 9) begin
        e = (flt & 'hfe) | thermistor_sense_pin;
        flt = fault_event;
      end
      host.byte_x(8'hff, i == n - 1, rd, ak);
      chk("rd data", rd, e);
    end
    host.stop();
  endtask

  task automatic set_fault(input logic [7:0] v);
    @(negedge clock);
    fault_event = v;
    flt = flt | v;
  endtask

  always @(posedge hang) begin
    n_errors++;
    end_sim();
  end

  initial begin
    seed = 47715;
    n_errors = 0;
    total_checks = 0;
    flt = 0;
    nrst = 1'b0;
    input_qual_ok = 4'h0;
    {src_detect_done, charging, charge_done, charge_suspend} = 4'h0;
    {boost_suspend, input_voltage_limit_event} = 2'h0;
    {input_current_limit_event, dpm_int_mask} = 2'h0;
    fault_event = 8'h00;
    thermistor_sense_pin = 1'b0;
    foreach (mem[i]) mem[i] = 0;
    mem[0] = `CSI_FIRST_REGISTER_INDEX_RST;
    mem[1] = `CSI_REG01_RST;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    repeat (8) @(negedge clock);
    chk("int idle", host_int_n, 1);
    rd_regs(0, 13);
    done("reset values and burst read");
    addr(7'h6a, 1'b0);
    chk("foreign addr", ak, 1);
    host.stop();
    addr(`CSI_TARGET_ADDR, 1'b0);
    host.byte_x(8'h0c, 1'b1, rd, ak);
    chk("bad index", ak, 1);
    host.stop();
    for (int i = 2; i < 6; i++) mem[i] = $random(seed) & 'hff;
    wr_regs(2, 4);
    rd_regs(2, 4);
    done("addressing and burst write");
    for (int i = 0; i < 8; i++) begin
      @(negedge clock);
      input_qual_ok = (i == 7) ? 4'hf : 4'($random(seed));
      src_detect_done = (i == 7) ? 1'b1 : 1'($random(seed));
      @(negedge clock);
      chk("good flag", input_good_flag,
          &input_qual_ok && src_detect_done);
      chk("good pin", input_good_pin_n,
          !(&input_qual_ok && src_detect_done));
    end
    repeat (IC + 8) @(negedge clock);
    done("input good");
    charging = 1'b1;
    for (int k = 3; k >= 0; k--) begin
      mem[0] = (mem[0] & 'h9f) | (k << 5);
      wr_regs(0, 1);
      st_chk(k == 3);
    end
    charging = 1'b0;
    charge_done = 1'b1;
    int_chk(IC);
    chk("stat done", stat_oe_n, 1);
    charge_done = 1'b0;
    for (int k = 0; k < 2; k++) begin
      charge_suspend = (k == 0);
      boost_suspend = (k == 1);
      blink_chk();
    end
    charge_suspend = 1'b0;
    boost_suspend = 1'b0;
    done("charge state pin");
    for (int j = 0; j < 4; j++) begin
      @(negedge clock);
      dpm_int_mask = j[1];
      input_voltage_limit_event = j[0];
      input_current_limit_event = !j[0];
      int_chk(j[1] ? 0 : IC);
      input_voltage_limit_event = 1'b0;
      input_current_limit_event = 1'b0;
    end
    done("limit interrupts");
    set_fault(8'h08);
    int_chk(IC);
    set_fault(8'h00);
    set_fault(8'h10);
    int_chk(0);
    rd_regs(9, 1);
    set_fault(8'h00);
    thermistor_sense_pin = 1'b1;
    repeat (IC + 8) @(negedge clock);
    chk("therm quiet", host_int_n, 1);
    rd_regs(9, 1);
    set_fault(8'h04);
    int_chk(IC);
    done("fault register");
    end_sim();
  end
endmodule

`default_nettype wire
